// ---- core/uisc_pkg.sv ----
// Register map and field layout for the interrupt status and clear block
package uisc_pkg;
    localparam logic [3:0] LINE_CONTROL_OFS    = 4'h3;
    localparam logic [3:0] SPECIAL_FUNC_OFS    = 4'h7;
    localparam logic [3:0] INT_STATUS_OFS      = 4'hf;
    localparam logic [7:0] SPECIAL_LCR_VALUE   = 8'hbf;
    localparam int         SFR_ACCESS_BIT      = 2;
    localparam int         CLEAR_ALL_BIT       = 0;
    localparam logic [7:0] LINE_CONTROL_RESET  = 8'h00;
    localparam logic [7:0] SPECIAL_FUNC_RESET  = 8'h00;
    localparam logic [6:0] STATUS_RESET        = 7'h00;
    localparam int         NUM_SOURCES         = 7;
endpackage : uisc_pkg

// ---- core/uisc_top.sv ----
// Interrupt status and clear register with gated access, classic Wishbone slave
// Notes on behaviour
// - The status register answers at its offset only while line control holds 0xBF and special function bit 2 is set.
// - Special function bit 2 opens access to the interrupt status register.
// - After reset every status bit reads zero.
// - Bit 7 reads one while the CTS/RTS change interrupt is pending.
// - Bit 6 reads one while the Xoff or special character interrupt is pending.
// - Bit 5 reads one while the modem status interrupt is pending.
// - Bit 4 reads one while the transmit holding interrupt is pending.
// - Bit 3 reads one while the receiver timeout interrupt is pending.
// - Bit 2 reads one while the receive holding interrupt is pending.
// - Bit 1 reads one while the receive line error interrupt is pending.
// - Writing one to bit 0 clears every status flag whose source is not high in that same cycle.
// - The clear-all bit returns to zero by itself and always reads zero.
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module uisc_top (
    input  wire logic       CLK_SYS,
    input  wire logic       RST_N,
    input  wire logic       WB_CYC_I,
    input  wire logic       WB_STB_I,
    input  wire logic       WB_WE_I,
    input  wire logic [3:0] WB_ADR_I,
    input  wire logic [0:0] WB_SEL_I,
    input  wire logic [7:0] WB_DAT_I,
    output logic      [7:0] WB_DAT_O,
    output logic            WB_ACK_O,
    input  wire logic [6:0] INT_SOURCES,
    output logic            SPECIAL_ACCESS_OPEN
);
    logic [7:0] line_control_reg_r;
    logic [7:0] special_function_reg_r;
    logic [6:0] status_r;
    logic [6:0] status_nxt;
    logic [7:0] dat_r;
    logic [7:0] dat_nxt;
    logic       ack_r;
    logic       req;
    logic       wr_en;
    logic       special_open;
    logic       clear_all;

    assign req          = WB_CYC_I && WB_STB_I && !ack_r;
    assign wr_en        = req && WB_WE_I && WB_SEL_I[0];
    assign special_open = (line_control_reg_r == uisc_pkg::SPECIAL_LCR_VALUE)
                          && special_function_reg_r[uisc_pkg::SFR_ACCESS_BIT];
    assign clear_all    = wr_en && special_open && (WB_ADR_I == uisc_pkg::INT_STATUS_OFS)
                          && WB_DAT_I[uisc_pkg::CLEAR_ALL_BIT];
    assign SPECIAL_ACCESS_OPEN = special_open;
    assign WB_ACK_O     = ack_r;
    assign WB_DAT_O     = dat_r;

    // Single-cycle acknowledge, dropped the cycle after it is given
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            line_control_reg_r <= uisc_pkg::LINE_CONTROL_RESET;
        end else if (wr_en && WB_ADR_I == uisc_pkg::LINE_CONTROL_OFS) begin
            line_control_reg_r <= WB_DAT_I;
        end
    end

    // Special function register itself is only writable in the 0xBF window
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            special_function_reg_r <= uisc_pkg::SPECIAL_FUNC_RESET;
        end else if (wr_en && WB_ADR_I == uisc_pkg::SPECIAL_FUNC_OFS
                     && line_control_reg_r == uisc_pkg::SPECIAL_LCR_VALUE) begin
            special_function_reg_r <= WB_DAT_I;
        end
    end

    // Sticky flags; a source that is high wins over a clear in the same cycle
    generate
        for (genvar i = 0; i < uisc_pkg::NUM_SOURCES; i++) begin : g_flag
            assign status_nxt[i] = (status_r[i] && !clear_all) || INT_SOURCES[i];
        end
    endgenerate

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            status_r <= uisc_pkg::STATUS_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Read mux; clear bit always reads zero, unmapped offsets read zero
    always_comb begin
        dat_nxt = 8'h00;
        case (WB_ADR_I)
            uisc_pkg::LINE_CONTROL_OFS: dat_nxt = line_control_reg_r;
            uisc_pkg::SPECIAL_FUNC_OFS: begin
                if (line_control_reg_r == uisc_pkg::SPECIAL_LCR_VALUE) begin
                    dat_nxt = special_function_reg_r;
                end
            end
            uisc_pkg::INT_STATUS_OFS: begin
                if (special_open) begin
                    dat_nxt = {status_r, 1'b0};
                end
            end
            default: dat_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            dat_r <= 8'h00;
        end else if (req) begin
            dat_r <= dat_nxt;
        end
    end

    // Named steps of a bus access
    sequence s_clear_write;
        clear_all && INT_SOURCES == 7'h00;
    endsequence

    sequence s_bus_take;
        WB_CYC_I && WB_STB_I && !ack_r;
    endsequence

    sequence s_status_rd;
        req && !WB_WE_I && WB_ADR_I == uisc_pkg::INT_STATUS_OFS;
    endsequence

    sequence s_key_lcr;
        wr_en && WB_ADR_I == uisc_pkg::LINE_CONTROL_OFS;
    endsequence

    sequence s_sfr_locked;
        wr_en && WB_ADR_I == uisc_pkg::SPECIAL_FUNC_OFS
        && line_control_reg_r != uisc_pkg::SPECIAL_LCR_VALUE;
    endsequence

    sequence s_other_rd;
        req && !WB_WE_I && WB_ADR_I != uisc_pkg::LINE_CONTROL_OFS
        && WB_ADR_I != uisc_pkg::SPECIAL_FUNC_OFS && WB_ADR_I != uisc_pkg::INT_STATUS_OFS;
    endsequence

    a_clear_empties: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        s_clear_write
        |=> status_r == 7'h00)
        else $error("clear-all did not empty status");

    a_flag_sticks: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        INT_SOURCES[6] ##1 !clear_all
        |=> status_r[6])
        else $error("cts flag lost");

    a_source_sets: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        INT_SOURCES[0]
        |=> status_r[0])
        else $error("line error flag not set");

    a_hold_stable: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (!clear_all && INT_SOURCES == 7'h00)
        |=> status_r == $past(status_r))
        else $error("flags changed without cause");

    a_reset_zero: assert property (@(posedge CLK_SYS)
        !RST_N
        |=> status_r == 7'h00)
        else $error("status not zero after reset");

    a_gate_closed: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        s_status_rd ##0 !special_open
        |=> WB_DAT_O == 8'h00)
        else $error("status visible while gated");

    a_clear_bit_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (req && WB_ADR_I == uisc_pkg::INT_STATUS_OFS)
        |=> WB_DAT_O[0] == 1'b0)
        else $error("clear bit read back as one");

    a_status_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        s_status_rd ##0 special_open
        |=> WB_DAT_O[7:1] == $past(status_r) && WB_ACK_O)
        else $error("status read mismatch");

    a_open_gate: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        SPECIAL_ACCESS_OPEN == (line_control_reg_r == uisc_pkg::SPECIAL_LCR_VALUE
        && special_function_reg_r[uisc_pkg::SFR_ACCESS_BIT]))
        else $error("access gate disagrees with key");

    a_ack_follows: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        s_bus_take
        |=> WB_ACK_O)
        else $error("request not acknowledged");

    a_ack_single: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        WB_ACK_O
        |=> !WB_ACK_O)
        else $error("acknowledge held too long");

    a_ack_idle: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !(WB_CYC_I && WB_STB_I)
        |=> !WB_ACK_O)
        else $error("acknowledge without request");

    a_lcr_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        s_key_lcr
        |=> line_control_reg_r == $past(WB_DAT_I))
        else $error("line control write lost");

    a_lcr_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (req && !WB_WE_I && WB_ADR_I == uisc_pkg::LINE_CONTROL_OFS)
        |=> WB_DAT_O == $past(line_control_reg_r))
        else $error("line control read mismatch");

    a_sfr_locked: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        s_sfr_locked
        |=> $stable(special_function_reg_r))
        else $error("special function written without key");

    a_sfr_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (wr_en && WB_ADR_I == uisc_pkg::SPECIAL_FUNC_OFS
        && line_control_reg_r == uisc_pkg::SPECIAL_LCR_VALUE)
        |=> special_function_reg_r == $past(WB_DAT_I))
        else $error("special function write lost");

    a_sfr_read_gate: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (req && !WB_WE_I && WB_ADR_I == uisc_pkg::SPECIAL_FUNC_OFS
        && line_control_reg_r != uisc_pkg::SPECIAL_LCR_VALUE)
        |=> WB_DAT_O == 8'h00)
        else $error("special function visible without key");

    a_unmapped_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        s_other_rd
        |=> WB_DAT_O == 8'h00)
        else $error("unmapped offset read nonzero");

    a_dat_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        !req
        |=> $stable(WB_DAT_O))
        else $error("read data changed without request");

    a_gated_write: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (wr_en && WB_ADR_I == uisc_pkg::INT_STATUS_OFS && !special_open && INT_SOURCES == 7'h00)
        |=> $stable(status_r))
        else $error("status changed by gated write");

    a_high_ignored: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        (wr_en && WB_ADR_I == uisc_pkg::INT_STATUS_OFS
        && !WB_DAT_I[uisc_pkg::CLEAR_ALL_BIT] && INT_SOURCES == 7'h00)
        |=> $stable(status_r))
        else $error("status changed without clear bit");

    a_open_drops: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
        s_key_lcr ##0 WB_DAT_I != uisc_pkg::SPECIAL_LCR_VALUE
        |=> !SPECIAL_ACCESS_OPEN)
        else $error("access open after key removed");

    a_regs_reset: assert property (@(posedge CLK_SYS)
        !RST_N
        |=> line_control_reg_r == uisc_pkg::LINE_CONTROL_RESET
        && special_function_reg_r == uisc_pkg::SPECIAL_FUNC_RESET)
        else $error("control registers not reset");

    a_bus_reset: assert property (@(posedge CLK_SYS)
        !RST_N
        |=> !WB_ACK_O && WB_DAT_O == 8'h00)
        else $error("bus outputs not reset");

    a_open_reset: assert property (@(posedge CLK_SYS)
        !RST_N
        |=> !SPECIAL_ACCESS_OPEN)
        else $error("access open after reset");

    // Per-flag checks
    generate
        for (genvar j = 0; j < uisc_pkg::NUM_SOURCES; j++) begin : g_flag_chk
            a_bit_sets: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
                INT_SOURCES[j]
                |=> status_r[j])
                else $error("status flag not set by its source");

            a_bit_sticks: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
                (status_r[j] && !clear_all)
                |=> status_r[j])
                else $error("status flag lost without clear");

            a_bit_clears: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
                (clear_all && !INT_SOURCES[j])
                |=> !status_r[j])
                else $error("status flag survived clear");

            a_bit_no_ghost: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
                (!status_r[j] && !INT_SOURCES[j])
                |=> !status_r[j])
                else $error("status flag set without source");

            a_bit_reads: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
                s_status_rd ##0 special_open
                |=> WB_DAT_O[j+1] == $past(status_r[j]))
                else $error("status bit read mismatch");

            a_bit_hidden: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
                s_status_rd ##0 !special_open
                |=> !WB_DAT_O[j+1])
                else $error("status bit visible while gated");

            a_bit_reset: assert property (@(posedge CLK_SYS)
                !RST_N
                |=> !status_r[j])
                else $error("status bit not reset");
        end
    endgenerate
endmodule : uisc_top
`default_nettype wire

// ---- dv/uisc_src_model.sv ----
// Interrupt source model: raises the selected source lines while fired
`timescale 1ns/1ps
`default_nettype none
module uisc_src_model (
    input  wire logic       fire,
    input  wire logic [6:0] mask,
    output logic      [6:0] srcs
);
    assign srcs = fire ? mask : 7'h00;
endmodule : uisc_src_model
`default_nettype wire

// ---- dv/uisc_tb.sv ----
// Self-checking testbench for the interrupt status and clear block
`timescale 1ns/1ps
`default_nettype none
module uart_interrupt_status_clear_tb;
    logic       clk_sys = 0, rst_n = 0, cyc = 0, we = 0, fire = 0, ack, open_w;
    logic [0:0] sel = 1'b1;
    logic [3:0] adr = 0;
    logic [7:0] wdat = 0, rdat, dat_o;
    logic [6:0] mask = 0, srcs, acc;
    int         error_cnt = 0, num_checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    uisc_src_model src (.fire(fire), .mask(mask), .srcs(srcs));
    uisc_top dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .INT_SOURCES(srcs), .SPECIAL_ACCESS_OPEN(open_w));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Classic cycle: hold until ack is sampled high at a rising edge, then one idle cycle
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        {cyc, we, adr, wdat} <= {1'b1, w, a, d};
        @(posedge clk_sys);
        while (ack !== 1'b1) @(posedge clk_sys);
        rdat = dat_o;
        {cyc, sel} <= {1'b0, 1'b1};
        @(posedge clk_sys);
    endtask : wb
    task automatic pulse(input logic [6:0] m);
        {fire, mask} <= {1'b1, m};
        @(posedge clk_sys);
        fire <= 1'b0;
        @(posedge clk_sys);
        acc = acc | m;
    endtask : pulse
    task automatic rd_status(input string nm, input logic [7:0] exp);
        wb(1'b0, uisc_pkg::INT_STATUS_OFS, 8'h00);
        chk(nm, rdat, exp);
    endtask : rd_status
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    initial begin
        repeat (4000) @(posedge clk_sys);
        error_cnt++;
        close_out();
    end
    initial begin
        void'($urandom(32'h33527051));
        acc = 7'h00;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd_status("closed status", 8'h00);
        wb(1'b1, uisc_pkg::LINE_CONTROL_OFS, uisc_pkg::SPECIAL_LCR_VALUE);
        wb(1'b1, uisc_pkg::SPECIAL_FUNC_OFS, 8'h04);
        chk("open", {7'h00, open_w}, 8'h01);
        rd_status("reset status", 8'h00);
        for (int i = 0; i < 7; i++) begin
            pulse(7'h01 << i);
            rd_status("flag", {acc, 1'b0});
        end
        wb(1'b1, uisc_pkg::INT_STATUS_OFS, 8'hfe);
        rd_status("no clear", 8'hfe);
        sel <= 1'b0;
        wb(1'b1, uisc_pkg::INT_STATUS_OFS, 8'h01);
        rd_status("masked clear", 8'hfe);
        wb(1'b0, uisc_pkg::LINE_CONTROL_OFS, 8'h00);
        chk("lcr read", rdat, uisc_pkg::SPECIAL_LCR_VALUE);
        wb(1'b1, uisc_pkg::INT_STATUS_OFS, 8'h01);
        acc = 7'h00;
        rd_status("clear all", 8'h00);
        {fire, mask} <= {1'b1, 7'h08};
        wb(1'b1, uisc_pkg::INT_STATUS_OFS, 8'h01);
        fire <= 1'b0;
        acc = 7'h08;
        rd_status("set wins", 8'h10);
        repeat (8) begin
            pulse(7'($urandom));
            rd_status("random flags", {acc, 1'b0});
            if ($urandom_range(1) == 1) begin
                wb(1'b1, uisc_pkg::INT_STATUS_OFS, 8'h01);
                acc = 7'h00;
                rd_status("random clear", 8'h00);
            end
        end
        pulse(7'h7f);
        wb(1'b1, uisc_pkg::LINE_CONTROL_OFS, 8'h00);
        chk("shut", {7'h00, open_w}, 8'h00);
        rd_status("shut status", 8'h00);
        wb(1'b1, uisc_pkg::INT_STATUS_OFS, 8'h01);
        wb(1'b1, uisc_pkg::LINE_CONTROL_OFS, uisc_pkg::SPECIAL_LCR_VALUE);
        rd_status("gated clear", 8'hfe);
        wb(1'b0, 4'hc, 8'h00);
        chk("unmapped", rdat, 8'h00);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk("reset gate", {7'h00, open_w}, 8'h00);
        wb(1'b1, uisc_pkg::LINE_CONTROL_OFS, uisc_pkg::SPECIAL_LCR_VALUE);
        wb(1'b1, uisc_pkg::SPECIAL_FUNC_OFS, 8'h04);
        rd_status("reset flags", 8'h00);
        close_out();
    end
endmodule : uart_interrupt_status_clear_tb
`default_nettype wire
